// File: hdl/trpc_regs.svh
`ifndef TRPC_REGS_SVH
`define TRPC_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define TRPC_CREST_OFS    8'h00
`define TRPC_SPAN_OFS     8'h04
`define TRPC_STAT_OFS     8'h08
`define TRPC_LIVE_OFS     8'h0c
`define TRPC_REL0_BLK     4'h1
`define TRPC_REL1_BLK     4'h2
`define TRPC_REL_IDX_BIT  5
`define TRPC_SUB_THR      2'h0
`define TRPC_SUB_LIM      2'h1
`define TRPC_SUB_CFG      2'h2
`define TRPC_SUB_DLY      2'h3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TRPC_STYLE_BIT    16
`define TRPC_MODE_LSB     16
`define TRPC_FAULT_LSB    19
`define TRPC_SRC_BIT      21
`define TRPC_UNIT_BIT     22
`define TRPC_FIT_BIT      23
`define TRPC_OFF_LSB      16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TRPC_CREST_RST    32'h0000_000a
`define TRPC_SPAN_RST     32'h0000_0032
`define TRPC_THR_RST      32'h0000_0000
`define TRPC_CFG_RST      32'h0080_0000
`define TRPC_DLY_RST      32'h0000_0000

// ----------------------------------------
// Display limits and bus answers
// ----------------------------------------
`define TRPC_DISP_MAX     18'h0270f
`define TRPC_DISP_MIN     18'h3fc19
`define TRPC_RESP_OKAY    2'h0
`define TRPC_RESP_SLVERR  2'h2

// ----------------------------------------
// Time base
// ----------------------------------------
`define TRPC_CLK_NS       100
`define TRPC_TBASE_NS     100000000
`define TRPC_UNIT_MUL     4'h9

`endif

// File: hdl/trpc_pkg.sv
package trpc_pkg;

	typedef enum logic [1:0]
	{
		TRPC_MAIN_VALUE = 2'h0,
		TRPC_MAIN_DASH  = 2'h1,
		TRPC_MAIN_PEAK  = 2'h2
	} trpc_main_e;

	typedef enum logic [2:0]
	{
		TRPC_SEC_BLANK = 3'h0,
		TRPC_SEC_OVER  = 3'h1,
		TRPC_SEC_UNDER = 3'h2,
		TRPC_SEC_OVF   = 3'h3,
		TRPC_SEC_THR   = 3'h4
	} trpc_sec_e;

	typedef enum logic [2:0]
	{
		TRPC_ZONE_UNUSED = 3'h0,
		TRPC_ZONE_ONE_ON = 3'h1,
		TRPC_ZONE_ONE_OFF = 3'h2,
		TRPC_ZONE_TWO_IN = 3'h3,
		TRPC_ZONE_TWO_OUT = 3'h4
	} trpc_zone_e;

	typedef enum logic [1:0]
	{
		TRPC_FAULT_KEEP = 2'h0,
		TRPC_FAULT_ON   = 2'h1,
		TRPC_FAULT_OFF  = 2'h2
	} trpc_fault_e;

	typedef enum logic [1:0]
	{
		TRPC_SEL_NONE = 2'h0,
		TRPC_SEL_A    = 2'h1,
		TRPC_SEL_B    = 2'h2
	} trpc_sel_e;

	typedef struct packed
	{
		logic              aw_full;
		logic [7:0]        aw_addr;
		logic              w_full;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              awrdy;
		logic              wrdy;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arrdy;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
		logic [31:0]       crest_cfg;
		logic [31:0]       span_cfg;
		logic [1:0][31:0]  thr_cfg;
		logic [1:0][31:0]  lim_cfg;
		logic [1:0][31:0]  rel_cfg;
		logic [1:0][31:0]  dly_cfg;
		logic [19:0]       tick_cnt;
		logic              tick;
		logic [3:0]        unit_cnt;
		logic              unit_tick;
		logic [15:0]       live;
		logic              over;
		logic              under;
		logic [15:0]       trk_lo;
		logic [15:0]       trk_hi;
		logic              armed;
		logic [15:0]       peak_val;
		logic              held;
		logic [15:0]       span_cnt;
		logic              blink;
		logic [1:0]        relay_st;
		logic [1:0][15:0]  dly_cnt;
		logic [1:0]        relay_out;
		logic [1:0]        relay_led;
		trpc_main_e        main_mode;
		logic [15:0]       main_val;
		trpc_sec_e         sec_mode;
		logic [15:0]       sec_val;
		logic              dp_right;
		trpc_sel_e         sel;
		logic              pick_a;
		logic              pick_b;
	} trpc_state_s;

endpackage

// File: hdl/trpc_top.sv
`timescale 1ns/10ps
`include "trpc_regs.svh"

module trpc_top
	import trpc_pkg::*;
#(
	parameter int TICK_CYC = `TRPC_TBASE_NS / `TRPC_CLK_NS
)
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	// AXI4-Lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Converter results
	input  wire logic        meas_valid,
	input  wire logic [15:0] meas_value,
	input  wire logic        meas_over,
	input  wire logic        meas_under,
	// Buttons
	input  wire logic        esc_btn,
	input  wire logic        up_btn,
	input  wire logic        down_btn,
	// Relays and LEDs
	output logic [1:0]       relay_out,
	output logic [1:0]       relay_led,
	output logic             threshold_pick_led_a,
	output logic             threshold_pick_led_b,
	// Display
	output trpc_main_e       main_mode,
	output logic [15:0]      main_val,
	output trpc_sec_e        sec_mode,
	output logic [15:0]      sec_val,
	output logic             dp_right
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				r[b*8 +: 8] = d[b*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic signed [17:0] sx(input logic [15:0] v);
		return $signed({{2{v[15]}}, v});
	endfunction

	trpc_state_s s;
	trpc_state_s n;
	logic [1:0]          rel_nx;
	logic [1:0][15:0]    cnt_nx;
	logic                fault;

	assign fault = s.over | s.under;

	// ----------------------------------------
	// Per-relay evaluation
	// ----------------------------------------
	generate
		for (genvar i = 0; i < 2; i++)
		begin : g_rel
			logic [31:0]       cfg;
			trpc_zone_e        zone;
			trpc_fault_e       fact;
			logic [15:0]       x;
			logic signed [17:0] xs, lo_t, hi_t, h;
			logic              two, za, zb, tgt_ok, tgt_on, utick;
			logic [15:0]       dly;
			logic              st;
			logic [15:0]       cnt;

			always_comb
			begin
				cfg   = s.rel_cfg[i];
				zone  = trpc_zone_e'(cfg[`TRPC_MODE_LSB +: 3]);
				fact  = trpc_fault_e'(cfg[`TRPC_FAULT_LSB +: 2]);
				x     = (cfg[`TRPC_SRC_BIT] && s.held) ? s.peak_val : s.live;
				xs    = sx(x);
				h     = sx(s.rel_cfg[i][15:0]);
				two   = (zone == TRPC_ZONE_TWO_IN) || (zone == TRPC_ZONE_TWO_OUT);
				lo_t  = sx(s.thr_cfg[i][15:0]);
				hi_t  = sx(s.lim_cfg[i][15:0]);
				if (two && (hi_t < lo_t))
				begin
					lo_t = sx(s.lim_cfg[i][15:0]);
					hi_t = sx(s.thr_cfg[i][15:0]);
				end
				if (two)
				begin
					za = (xs > lo_t + h) && (xs < hi_t - h);
					zb = (xs < lo_t - h) || (xs > hi_t + h);
				end
				else
				begin
					za = xs > lo_t + h;
					zb = xs < lo_t - h;
				end
				tgt_ok = za | zb;
				tgt_on = ((zone == TRPC_ZONE_ONE_ON) || (zone == TRPC_ZONE_TWO_IN)) ? za : zb;
				dly    = tgt_on ? s.dly_cfg[i][15:0] : s.dly_cfg[i][`TRPC_OFF_LSB +: 16];
				utick  = cfg[`TRPC_UNIT_BIT] ? s.unit_tick : s.tick;
				st     = s.relay_st[i];
				cnt    = s.dly_cnt[i];
				if (zone == TRPC_ZONE_UNUSED)
				begin
					st  = 1'b0;
					cnt = '0;
				end
				else if (fault)
				begin
					cnt = '0;
					if (fact == TRPC_FAULT_ON)
						st = 1'b1;
					else if (fact == TRPC_FAULT_OFF)
						st = 1'b0;
				end
				else if (!tgt_ok || (tgt_on == st))
					cnt = '0;
				else if (dly == '0)
				begin
					st  = tgt_on;
					cnt = '0;
				end
				else if (utick)
				begin
					if (cnt >= dly)
					begin
						st  = tgt_on;
						cnt = '0;
					end
					else
						cnt = cnt + 16'(1);
				end
			end

			assign rel_nx[i] = st;
			assign cnt_nx[i] = cnt;
		end
	endgenerate

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		logic              rhit, whit, wi, ri, ovf, warn, det, freeze;
		logic [15:0]       span;
		logic signed [17:0] xv;
		rhit   = 1'b0;
		whit   = 1'b0;
		wi     = 1'b0;
		ri     = 1'b0;
		ovf    = 1'b0;
		warn   = 1'b0;
		det    = 1'b0;
		span   = s.span_cfg[15:0];
		freeze = s.crest_cfg[`TRPC_STYLE_BIT];
		xv     = sx(meas_value);
		n      = s;

		// Bus write: address and data in either order
		if (s_axi_awvalid && s.awrdy)
		begin
			n.aw_full = 1'b1;
			n.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wrdy)
		begin
			n.w_full = 1'b1;
			n.wdata  = s_axi_wdata;
			n.wstrb  = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready)
			n.bvalid = 1'b0;
		if (s.aw_full && s.w_full && !s.bvalid)
		begin
			wi = s.aw_addr[`TRPC_REL_IDX_BIT];
			whit = (s.aw_addr[7:4] == `TRPC_REL0_BLK) || (s.aw_addr[7:4] == `TRPC_REL1_BLK);
			n.bresp = `TRPC_RESP_OKAY;
			if (s.aw_addr == `TRPC_CREST_OFS)
				n.crest_cfg = wmerge(s.crest_cfg, s.wdata, s.wstrb);
			else if (s.aw_addr == `TRPC_SPAN_OFS)
				n.span_cfg = wmerge(s.span_cfg, s.wdata, s.wstrb);
			else if (whit)
			begin
				unique case (s.aw_addr[3:2])
					`TRPC_SUB_THR: n.thr_cfg[wi] = wmerge(s.thr_cfg[wi], s.wdata, s.wstrb);
					`TRPC_SUB_LIM: n.lim_cfg[wi] = wmerge(s.lim_cfg[wi], s.wdata, s.wstrb);
					`TRPC_SUB_CFG: n.rel_cfg[wi] = wmerge(s.rel_cfg[wi], s.wdata, s.wstrb);
					`TRPC_SUB_DLY: n.dly_cfg[wi] = wmerge(s.dly_cfg[wi], s.wdata, s.wstrb);
				endcase
			end
			else if (s.aw_addr != `TRPC_STAT_OFS && s.aw_addr != `TRPC_LIVE_OFS)
				n.bresp = `TRPC_RESP_SLVERR;
			n.bvalid  = 1'b1;
			n.aw_full = 1'b0;
			n.w_full  = 1'b0;
		end
		n.awrdy = !n.aw_full && !n.bvalid;
		n.wrdy  = !n.w_full && !n.bvalid;

		// Bus read
		if (s.rvalid && s_axi_rready)
			n.rvalid = 1'b0;
		if (s_axi_arvalid && s.arrdy)
		begin
			ri   = s_axi_araddr[`TRPC_REL_IDX_BIT];
			rhit = (s_axi_araddr[7:4] == `TRPC_REL0_BLK) || (s_axi_araddr[7:4] == `TRPC_REL1_BLK);
			n.rvalid = 1'b1;
			n.rresp  = `TRPC_RESP_OKAY;
			n.rdata  = '0;
			if (s_axi_araddr == `TRPC_CREST_OFS)
				n.rdata = s.crest_cfg;
			else if (s_axi_araddr == `TRPC_SPAN_OFS)
				n.rdata = s.span_cfg;
			else if (s_axi_araddr == `TRPC_STAT_OFS)
				n.rdata = {s.peak_val, 8'(0), s.sel, s.relay_st, s.held,
					s.sec_mode == TRPC_SEC_OVF, s.under, s.over};
			else if (s_axi_araddr == `TRPC_LIVE_OFS)
				n.rdata = {16'(0), s.live};
			else if (rhit)
			begin
				unique case (s_axi_araddr[3:2])
					`TRPC_SUB_THR: n.rdata = s.thr_cfg[ri];
					`TRPC_SUB_LIM: n.rdata = s.lim_cfg[ri];
					`TRPC_SUB_CFG: n.rdata = s.rel_cfg[ri];
					`TRPC_SUB_DLY: n.rdata = s.dly_cfg[ri];
				endcase
			end
			else
				n.rresp = `TRPC_RESP_SLVERR;
		end
		n.arrdy = !n.rvalid;

		// Time base
		n.tick      = 1'b0;
		n.unit_tick = 1'b0;
		if (s.tick_cnt == 20'(TICK_CYC - 1))
		begin
			n.tick_cnt = '0;
			n.tick     = 1'b1;
			n.blink    = !s.blink;
			if (s.unit_cnt == `TRPC_UNIT_MUL)
			begin
				n.unit_cnt  = '0;
				n.unit_tick = 1'b1;
			end
			else
				n.unit_cnt = s.unit_cnt + 4'(1);
		end
		else
			n.tick_cnt = s.tick_cnt + 20'(1);

		// Measurement capture and peak tracking
		if (meas_valid)
		begin
			n.live  = meas_value;
			n.over  = meas_over;
			n.under = meas_under;
			if (!meas_over && !meas_under)
			begin
				if (!s.armed)
				begin
					n.trk_hi = meas_value;
					if (xv < sx(s.trk_lo))
						n.trk_lo = meas_value;
					else if (xv - sx(s.trk_lo) >= sx(s.crest_cfg[15:0]))
						n.armed = 1'b1;
				end
				else if (xv > sx(s.trk_hi))
					n.trk_hi = meas_value;
				else if (sx(s.trk_hi) - xv >= sx(s.crest_cfg[15:0]))
				begin
					det      = 1'b1;
					n.armed  = 1'b0;
					n.trk_lo = meas_value;
					n.trk_hi = meas_value;
				end
			end
		end

		// Peak hold
		if (det)
		begin
			n.peak_val = s.trk_hi;
			n.span_cnt = '0;
			n.held     = (span != '0) || freeze;
		end
		else if (s.held && span != '0 && s.tick)
		begin
			if (s.span_cnt + 16'(1) >= span)
				n.held = 1'b0;
			else
				n.span_cnt = s.span_cnt + 16'(1);
		end
		else if (s.held && span == '0 && (esc_btn || !freeze))
			n.held = 1'b0;

		// Relays and LEDs
		n.relay_st = rel_nx;
		n.dly_cnt  = cnt_nx;
		n.relay_led = rel_nx;
		for (int k = 0; k < 2; k++)
			n.relay_out[k] = rel_nx[k] & s.rel_cfg[k][`TRPC_FIT_BIT];

		// Threshold quick view
		if (up_btn)
		begin
			unique case (s.sel)
				TRPC_SEL_NONE: n.sel = TRPC_SEL_A;
				TRPC_SEL_A:    n.sel = TRPC_SEL_B;
				TRPC_SEL_B:    n.sel = TRPC_SEL_NONE;
				default:       n.sel = TRPC_SEL_NONE;
			endcase
		end
		else if (down_btn)
		begin
			unique case (s.sel)
				TRPC_SEL_NONE: n.sel = TRPC_SEL_B;
				TRPC_SEL_A:    n.sel = TRPC_SEL_NONE;
				TRPC_SEL_B:    n.sel = TRPC_SEL_A;
				default:       n.sel = TRPC_SEL_NONE;
			endcase
		end
		n.pick_a = n.sel == TRPC_SEL_A;
		n.pick_b = n.sel == TRPC_SEL_B;

		// Display selection
		ovf  = (sx(n.live) > $signed(`TRPC_DISP_MAX)) ||
			(sx(n.live) < $signed(`TRPC_DISP_MIN));
		warn = n.over || n.under || ovf;
		if (warn)
		begin
			n.main_mode = TRPC_MAIN_DASH;
			n.main_val  = '0;
			n.sec_val   = '0;
			if (n.over)
				n.sec_mode = TRPC_SEC_OVER;
			else if (n.under)
				n.sec_mode = TRPC_SEC_UNDER;
			else
				n.sec_mode = TRPC_SEC_OVF;
		end
		else
		begin
			n.main_mode = n.held ? TRPC_MAIN_PEAK : TRPC_MAIN_VALUE;
			n.main_val  = n.held ? n.peak_val : n.live;
			n.sec_mode  = (n.sel == TRPC_SEL_NONE) ? TRPC_SEC_BLANK : TRPC_SEC_THR;
			n.sec_val   = (n.sel == TRPC_SEL_B) ? n.thr_cfg[1][15:0] :
				(n.sel == TRPC_SEL_A) ? n.thr_cfg[0][15:0] : 16'(0);
		end
		n.dp_right = n.held && n.blink && !warn;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s            <= '0;
			s.crest_cfg  <= `TRPC_CREST_RST;
			s.span_cfg   <= `TRPC_SPAN_RST;
			s.thr_cfg    <= {2{`TRPC_THR_RST}};
			s.lim_cfg    <= {2{`TRPC_THR_RST}};
			s.rel_cfg    <= {2{`TRPC_CFG_RST}};
			s.dly_cfg    <= {2{`TRPC_DLY_RST}};
			s.main_mode  <= TRPC_MAIN_VALUE;
			s.sec_mode   <= TRPC_SEC_BLANK;
			s.sel        <= TRPC_SEL_NONE;
		end
		else
			s <= n;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign s_axi_awready        = s.awrdy;
	assign s_axi_wready         = s.wrdy;
	assign s_axi_bresp          = s.bresp;
	assign s_axi_bvalid         = s.bvalid;
	assign s_axi_arready        = s.arrdy;
	assign s_axi_rdata          = s.rdata;
	assign s_axi_rresp          = s.rresp;
	assign s_axi_rvalid         = s.rvalid;
	assign relay_out            = s.relay_out;
	assign relay_led            = s.relay_led;
	assign threshold_pick_led_a = s.pick_a;
	assign threshold_pick_led_b = s.pick_b;
	assign main_mode            = s.main_mode;
	assign main_val             = s.main_val;
	assign sec_mode             = s.sec_mode;
	assign sec_val              = s.sec_val;
	assign dp_right             = s.dp_right;

endmodule

// File: bench/trpc_chk_sva.sv
`timescale 1ns/10ps
module trpc_chk
	import trpc_pkg::*;
#(
	parameter int TICK_CYC = 10
)
(
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	// Bus and inputs
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        meas_valid,
	input wire logic [15:0] meas_value,
	input wire logic        meas_over,
	input wire logic        meas_under,
	input wire logic        up_btn,
	// Outputs
	input wire logic [1:0]  relay_out,
	input wire logic [1:0]  relay_led,
	input wire logic        threshold_pick_led_a,
	input wire logic        threshold_pick_led_b,
	input wire trpc_main_e  main_mode,
	input wire logic [15:0] main_val,
	input wire trpc_sec_e   sec_mode,
	input wire logic        dp_right
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	a_warn_dash: assert property (
		sec_mode inside {TRPC_SEC_OVER, TRPC_SEC_UNDER, TRPC_SEC_OVF}
		|-> main_mode == TRPC_MAIN_DASH && main_val == 16'h0000) else $error("dash missing");
	a_over_msg: assert property (meas_valid && meas_over |=> sec_mode == TRPC_SEC_OVER)
		else $error("over message missing");
	a_under_msg: assert property (meas_valid && !meas_over && meas_under
		|=> sec_mode == TRPC_SEC_UNDER) else $error("under message missing");
	a_ovf_msg: assert property (meas_valid && !meas_over && !meas_under
		&& ($signed(meas_value) > 16'sd9999 || $signed(meas_value) < -16'sd999)
		|=> sec_mode == TRPC_SEC_OVF) else $error("overflow message missing");
	a_led_follow: assert property ((relay_out & ~relay_led) == 2'h0)
		else $error("led not following relay");
	a_dp_quiet: assert property (main_mode == TRPC_MAIN_DASH [*2] |-> !dp_right)
		else $error("point lit during warning");
	a_pick_one: assert property (threshold_pick_led_a |-> !threshold_pick_led_b)
		else $error("both pick leds lit");
	a_up_step: assert property (up_btn && !threshold_pick_led_a && !threshold_pick_led_b
		|=> threshold_pick_led_a) else $error("up step missing");
	a_pick_wrap: assert property (up_btn && threshold_pick_led_b
		|=> !threshold_pick_led_a && !threshold_pick_led_b) else $error("pick wrap missing");
	a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while busy");

	c_relay_on: cover property ($rose(relay_out[0]));
	c_ovf: cover property (sec_mode == TRPC_SEC_OVF);
	c_peak: cover property (main_mode == TRPC_MAIN_PEAK);
endmodule

bind trpc_top trpc_chk #(.TICK_CYC(TICK_CYC)) trpc_chk_inst (.clk_sys(clk_sys),
	.sys_rst(sys_rst), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.meas_valid(meas_valid), .meas_value(meas_value), .meas_over(meas_over),
	.meas_under(meas_under), .up_btn(up_btn), .relay_out(relay_out), .relay_led(relay_led),
	.threshold_pick_led_a(threshold_pick_led_a), .threshold_pick_led_b(threshold_pick_led_b),
	.main_mode(main_mode), .main_val(main_val), .sec_mode(sec_mode), .dp_right(dp_right));

// File: bench/trpc_panel_model.sv
`timescale 1ns/10ps
module trpc_panel_model
(
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       sys_rst,
	// Relay coils
	input wire logic [1:0] relay_out,
	output int             moves
);
	logic [1:0] last_reg;

	// Counts contact movements, so chatter shows
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			moves <= 0;
			last_reg <= 2'h0;
		end
		else
		begin
			moves <= moves + $countones(relay_out ^ last_reg);
			last_reg <= relay_out;
		end
	end
endmodule

// File: bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import trpc_pkg::*;
	localparam int TICK = 10;
	localparam int LIMIT = 20000;
	logic        clk_sys, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, meas_valid, meas_over, meas_under, esc_btn, up_btn, down_btn;
	logic        threshold_pick_led_a, threshold_pick_led_b, dp_right;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, relay_out, relay_led, rsp;
	logic [15:0] meas_value, main_val, sec_val;
	trpc_main_e  main_mode;
	trpc_sec_e   sec_mode;
	int          failures, checked, cyc, moves, m0, rl0, rl1, v;
	int          va[4] = '{111, 95, 89, 105};
	int          vb[6] = '{150, 250, 150, 50, 150, 250};
	logic [31:0] fc[2] = '{32'h008a000a, 32'h0091000a};
	logic [1:0]  pk[4] = '{2'h1, 2'h2, 2'h0, 2'h2};

	trpc_top #(.TICK_CYC(TICK)) trpc_top_inst (.clk_sys, .sys_rst, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .meas_valid, .meas_value, .meas_over, .meas_under, .esc_btn, .up_btn,
		.down_btn, .relay_out, .relay_led, .threshold_pick_led_a, .threshold_pick_led_b,
		.main_mode, .main_val, .sec_mode, .sec_val, .dp_right);
	trpc_panel_model trpc_panel_model_inst (.clk_sys, .sys_rst, .relay_out, .moves);

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic give_verdict;
		if (failures == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, b;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		b = 1'b0;
		while (!b)
		begin
			@(negedge clk_sys);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge clk_sys);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask

	task automatic rdr(input logic [7:0] a);
		logic ar, r;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		r = 1'b0;
		while (!r)
		begin
			@(negedge clk_sys);
			ar = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid;
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge clk_sys);
			if (ar) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask

	task automatic ms(input int x, input logic ov, input logic un);
		@(posedge clk_sys);
		meas_valid <= 1'b1;
		meas_value <= x[15:0];
		meas_over <= ov;
		meas_under <= un;
		@(posedge clk_sys);
		meas_valid <= 1'b0;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask

	task automatic btn(input logic up);
		@(posedge clk_sys);
		up_btn <= up;
		down_btn <= !up;
		@(posedge clk_sys);
		up_btn <= 1'b0;
		down_btn <= 1'b0;
		@(negedge clk_sys);
	endtask

	// ----------------------------------------
	// Reference model
	// ----------------------------------------
	function automatic int sec_exp(int x, logic ov, logic un);
		return ov ? 1 : un ? 2 : (x > 9999 || x < -999) ? 3 : 0;
	endfunction

	function automatic int one_thr(int x, int t, int b, int p);
		return x > t + b ? 1 : x < t - b ? 0 : p;
	endfunction

	function automatic int two_thr(int x, int t1, int t2, int b, int p);
		int lo, hi;
		lo = t1 < t2 ? t1 : t2;
		hi = t1 < t2 ? t2 : t1;
		return (x > lo + b && x < hi - b) ? 1 : (x < lo - b || x > hi + b) ? 0 : p;
	endfunction

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic disp(input int x, input logic ov, input logic un);
		int e;
		ms(x, ov, un);
		e = sec_exp(x, ov, un);
		chk(sec_mode, e);
		chk(main_mode, e == 0 ? 0 : 1);
		chk(main_val, e == 0 ? x & 32'hffff : 0);
	endtask

	task automatic wait_rel(input logic exp);
		for (int i = 0; i < 60 && relay_out[0] !== exp; i++)
			@(negedge clk_sys);
	endtask

	// ----------------------------------------
	// Clock, timeout and main sequence
	// ----------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			failures++;
			give_verdict();
		end
	end

	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{meas_valid, meas_over, meas_under, esc_btn, up_btn, down_btn} = 6'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		meas_value = 16'h0;
		sys_rst = 1'b1;
		seed = 32'hc9eadcef;
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(negedge clk_sys);
		chk(sec_mode, 0);
		rdr(8'h00);
		chk(rd, 32'h0000000a);
		rdr(8'h04);
		chk(rd, 32'h00000032);
		rdr(8'h18);
		chk(rd, 32'h00800000);
		rdr(8'h2c);
		chk(rd, 32'h0);
		rdr(8'h40);
		chk(rsp, 2'h2);
		chk(rd, 32'h0);
		wr(8'h40, 32'h1);
		chk(rsp, 2'h2);
		wr(8'h00, 32'h00007fff);
		wr(8'h04, 32'h0);
		foreach (va[i]) disp(va[i] + 9888, 1'b0, 1'b0);
		disp(-999, 1'b0, 1'b0);
		disp(-1000, 1'b0, 1'b0);
		disp(0, 1'b0, 1'b1);
		for (int i = 0; i < 12; i++)
		begin
			seed = xs(seed);
			disp(int'(seed % 11000) - 1000, 1'b0, 1'b0);
		end
		ms(0, 1'b0, 1'b0);
		wr(8'h10, 32'd100);
		wr(8'h18, 32'h0081000a);
		rl0 = 0;
		m0 = moves;
		foreach (va[i])
		begin
			ms(va[i], 1'b0, 1'b0);
			rl0 = one_thr(va[i], 100, 10, rl0);
			chk(relay_out[0], rl0);
		end
		chk(moves - m0, 2);
		wr(8'h18, 32'h0082000a);
		foreach (va[i])
		begin
			ms(va[i], 1'b0, 1'b0);
			rl0 = one_thr(va[i], 100, 10, rl0);
			chk(relay_out[0], 1 - rl0);
		end
		foreach (fc[i])
		begin
			wr(8'h18, fc[i]);
			disp(111, 1'b0, 1'b0);
			chk(relay_out[0], i);
			disp(111, 1'b1, 1'b0);
			chk(relay_out[0], 1 - i);
		end
		wr(8'h18, 32'h0081000a);
		ms(0, 1'b0, 1'b0);
		wr(8'h1c, 32'h00030003);
		ms(111, 1'b0, 1'b0);
		repeat (12) @(negedge clk_sys);
		chk(relay_out[0], 0);
		wait_rel(1'b1);
		chk(relay_out[0], 1);
		ms(0, 1'b0, 1'b0);
		repeat (12) @(negedge clk_sys);
		ms(111, 1'b0, 1'b0);
		repeat (60) @(negedge clk_sys);
		chk(relay_out[0], 1);
		ms(150, 1'b0, 1'b0);
		wr(8'h20, 32'd200);
		wr(8'h24, 32'd100);
		wr(8'h28, 32'h00830005);
		rl1 = 1;
		foreach (vb[i])
		begin
			if (i == 4) wr(8'h28, 32'h00840005);
			ms(vb[i], 1'b0, 1'b0);
			rl1 = two_thr(vb[i], 200, 100, 5, rl1);
			chk(relay_out[1], i < 4 ? rl1 : 1 - rl1);
		end
		wr(8'h20, 32'd100);
		wr(8'h24, 32'd200);
		wr(8'h28, 32'h00830005);
		ms(150, 1'b0, 1'b0);
		chk(relay_out[1], 1);
		wr(8'h28, 32'h00030005);
		@(negedge clk_sys);
		chk({relay_out[1], relay_led[1]}, 2'h1);
		wr(8'h00, 32'h00010014);
		ms(0, 1'b0, 1'b0);
		ms(50, 1'b0, 1'b0);
		ms(25, 1'b0, 1'b0);
		chk({main_mode, main_val}, {TRPC_MAIN_PEAK, 16'd50});
		m0 = dp_right;
		repeat (TICK) @(negedge clk_sys);
		chk(dp_right, 1 - m0);
		repeat (TICK) @(negedge clk_sys);
		chk(main_mode, TRPC_MAIN_PEAK);
		@(posedge clk_sys);
		esc_btn <= 1'b1;
		@(posedge clk_sys);
		esc_btn <= 1'b0;
		repeat (3) @(negedge clk_sys);
		chk({main_mode, main_val, dp_right}, {TRPC_MAIN_VALUE, 16'd25, 1'b0});
		wr(8'h04, 32'h3);
		wr(8'h20, 32'd120);
		ms(0, 1'b0, 1'b0);
		ms(50, 1'b0, 1'b0);
		ms(25, 1'b0, 1'b0);
		chk({main_mode, main_val}, {TRPC_MAIN_PEAK, 16'd50});
		repeat (4 * TICK) @(negedge clk_sys);
		chk({main_mode, main_val}, {TRPC_MAIN_VALUE, 16'd25});
		foreach (pk[i])
		begin
			btn(i < 3);
			chk({threshold_pick_led_b, threshold_pick_led_a}, pk[i]);
			chk({sec_mode, sec_val}, pk[i] ? {TRPC_SEC_THR, pk[i] == 2'h2 ? 16'd120 : 16'd100} : 19'h0);
		end
		give_verdict();
	end
endmodule
